/* hdl/sd_status_capture.sv */
// Serial capture of the 512-bit card status block
`timescale 1ns/1ns
module sd_status_capture (
   input  wire logic                                mclk,
   input  wire logic                                rst,
   input  wire logic                                armed,
   input  wire logic                                frameStart,
   input  wire logic                                bitIn,
   input  wire logic                                bitValid,
   output logic [sd_status_pkg::BLOCK_BITS-1:0]     block,
   output logic                                     blockDone
);
   logic [sd_status_pkg::CNT_W-1:0] count;

   // Most significant bit arrives first
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         count <= '0;
      end else if (!armed || frameStart) begin
         count <= '0;
      end else if (bitValid) begin
         count <= count + 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         block <= '0;
      end else if (armed && bitValid && !frameStart) begin
         block <= {block[sd_status_pkg::BLOCK_BITS-2:0], bitIn};
      end
   end

   // Done only once the whole block is in
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         blockDone <= 1'b0;
      end else begin
         blockDone <= armed && bitValid && !frameStart && count == sd_status_pkg::LAST_BIT; // RL1
      end
   end
endmodule : sd_status_capture

/* hdl/sd_status_decoder.sv */
// Status block requester and field decoder with AXI4-Lite registers
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
module sd_status_decoder (
   input  wire logic                                mclk,
   input  wire logic                                rst,
   input  wire logic [sd_status_pkg::ADDR_W-1:0]    awaddr,
   input  wire logic                                awvalid,
   output logic                                     awready,
   input  wire logic [31:0]                         wdata,
   input  wire logic [3:0]                          wstrb,
   input  wire logic                                wvalid,
   output logic                                     wready,
   output logic [1:0]                               bresp,
   output logic                                     bvalid,
   input  wire logic                                bready,
   input  wire logic [sd_status_pkg::ADDR_W-1:0]    araddr,
   input  wire logic                                arvalid,
   output logic                                     arready,
   output logic [31:0]                              rdata,
   output logic [1:0]                               rresp,
   output logic                                     rvalid,
   input  wire logic                                rready,
   input  wire logic                                cardInTransfer,
   output logic                                     cmdValid,
   output logic [5:0]                               cmdIndex,
   input  wire logic                                cmdReady,
   input  wire logic                                frameStart,
   input  wire logic                                bitIn,
   input  wire logic                                bitValid,
   output logic                                     captureArmed
);
   sd_status_pkg::req_state_t state;
   sd_status_pkg::req_state_t next_state;

   logic [sd_status_pkg::BLOCK_BITS-1:0] block;
   logic                                 blockDone;
   logic                                 awHeld;
   logic                                 wHeld;
   logic [sd_status_pkg::ADDR_W-1:0]     awAddrHeld;
   logic [31:0]                          wDataHeld;
   logic [3:0]                           wStrbHeld;
   logic                                 doWrite;
   logic                                 ctrlWrite;
   logic                                 startReq;
   logic                                 clrDone;
   logic                                 clrRefused;
   logic                                 done;
   logic                                 refused;

   logic [1:0]  eraseOffset;
   logic [5:0]  eraseTimeout;
   logic [15:0] eraseSize;
   logic [3:0]  alloc_unit_length;
   logic [7:0]  movePerf;
   logic [7:0]  speedCode;
   logic [31:0] protected_region_length;
   logic [15:0] card_variant_code;
   logic        secure_operation_flag;
   logic [1:0]  current_lane_width;

   logic        tmoUnsupported;
   logic        moveInfinite;
   logic        moveUndefined;
   logic        speedReserved;
   logic [3:0]  speedClassNum;
   logic        auValid;
   logic [12:0] auKb;
   logic        cardStandard;
   logic        cardReadWrite;
   logic        cardReadOnly;
   logic        widthReserved;
   logic        widthFour;
   logic [31:0] readWord;
   logic        readHit;

   sd_status_capture capture (
      .mclk       (mclk),
      .rst        (rst),
      .armed      (captureArmed),
      .frameStart (frameStart),
      .bitIn      (bitIn),
      .bitValid   (bitValid),
      .block      (block),
      .blockDone  (blockDone)
   );

   // Write address and data are taken in either order
   assign awready   = !awHeld && !bvalid;
   assign wready    = !wHeld && !bvalid;
   assign doWrite   = awHeld && wHeld && !bvalid;
   assign ctrlWrite = doWrite && awAddrHeld == sd_status_pkg::OFS_CTRL && wStrbHeld[0];
   assign startReq  = ctrlWrite && wDataHeld[sd_status_pkg::CTRL_START];
   assign clrDone   = ctrlWrite && wDataHeld[sd_status_pkg::CTRL_CLR_DONE];
   assign clrRefused = ctrlWrite && wDataHeld[sd_status_pkg::CTRL_CLR_REF];

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         awHeld     <= 1'b0;
         awAddrHeld <= '0;
      end else if (awvalid && awready) begin
         awHeld     <= 1'b1;
         awAddrHeld <= awaddr;
      end else if (doWrite) begin
         awHeld <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wHeld     <= 1'b0;
         wDataHeld <= '0;
         wStrbHeld <= '0;
      end else if (wvalid && wready) begin
         wHeld     <= 1'b1;
         wDataHeld <= wdata;
         wStrbHeld <= wstrb;
      end else if (doWrite) begin
         wHeld <= 1'b0;
      end
   end

   // Only the control word is writable; other mapped words ignore writes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp  <= sd_status_pkg::RESP_OKAY;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         bresp  <= readHitFor(awAddrHeld) ? sd_status_pkg::RESP_OKAY : sd_status_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   function automatic logic readHitFor(input logic [sd_status_pkg::ADDR_W-1:0] a);
      readHitFor = a == sd_status_pkg::OFS_CTRL || a == sd_status_pkg::OFS_STATUS
                || a == sd_status_pkg::OFS_ERASE || a == sd_status_pkg::OFS_PERF
                || a == sd_status_pkg::OFS_PROT || a == sd_status_pkg::OFS_TYPE
                || a == sd_status_pkg::OFS_AU;
   endfunction : readHitFor

   // Request sequencer
   always_comb begin
      next_state = state;
      case (state)
         sd_status_pkg::ST_IDLE: begin
            if (startReq && cardInTransfer) begin // RL3
               next_state = sd_status_pkg::ST_APP;
            end
         end
         sd_status_pkg::ST_APP: begin
            if (cmdReady) begin
               next_state = sd_status_pkg::ST_STAT; // RL2
            end
         end
         sd_status_pkg::ST_STAT: begin
            if (cmdReady) begin
               next_state = sd_status_pkg::ST_WAIT;
            end
         end
         sd_status_pkg::ST_WAIT: begin
            if (blockDone) begin
               next_state = sd_status_pkg::ST_IDLE;
            end
         end
         default: next_state = sd_status_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= sd_status_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign cmdValid     = state == sd_status_pkg::ST_APP || state == sd_status_pkg::ST_STAT;
   assign captureArmed = state == sd_status_pkg::ST_WAIT;

   // Prefix first, status command immediately after
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmdIndex <= sd_status_pkg::CMD_APP_PREFIX;
      end else if (next_state == sd_status_pkg::ST_STAT) begin
         cmdIndex <= sd_status_pkg::CMD_STATUS; // RL2
      end else begin
         cmdIndex <= sd_status_pkg::CMD_APP_PREFIX;
      end
   end

   // Sticky flags; a set in the same cycle beats the clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         done <= 1'b0;
      end else if (blockDone) begin
         done <= 1'b1;
      end else if (clrDone) begin
         done <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         refused <= 1'b0;
      end else if (startReq && (state != sd_status_pkg::ST_IDLE || !cardInTransfer)) begin
         refused <= 1'b1; // RL3
      end else if (clrRefused) begin
         refused <= 1'b0;
      end
   end

   // Fields are taken only from a complete block; bits 399:0 are not used
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         eraseOffset             <= '0;
         eraseTimeout            <= '0;
         eraseSize               <= '0;
         alloc_unit_length       <= '0;
         movePerf                <= '0;
         speedCode               <= '0;
         protected_region_length <= '0;
         card_variant_code       <= '0;
         secure_operation_flag   <= 1'b0;
         current_lane_width      <= '0;
      end else if (blockDone) begin // RL1 RL6
         eraseOffset  <= block[sd_status_pkg::ERASE_OFS_LSB +: sd_status_pkg::ERASE_OFS_W]; // RL14
         eraseTimeout <= block[sd_status_pkg::ERASE_TMO_LSB +: sd_status_pkg::ERASE_TMO_W]; // RL14
         eraseSize    <= block[sd_status_pkg::ERASE_SIZE_LSB +: sd_status_pkg::ERASE_SIZE_W]; // RL14
         alloc_unit_length <= block[sd_status_pkg::AU_LSB +: sd_status_pkg::AU_W]; // RL7
         movePerf     <= block[sd_status_pkg::MOVE_LSB +: sd_status_pkg::MOVE_W]; // RL8
         speedCode    <= block[sd_status_pkg::SPEED_LSB +: sd_status_pkg::SPEED_W]; // RL9
         protected_region_length <= block[sd_status_pkg::PROT_LSB +: sd_status_pkg::PROT_W]; // RL10
         card_variant_code <= block[sd_status_pkg::TYPE_LSB +: sd_status_pkg::TYPE_W]; // RL11
         secure_operation_flag <= block[sd_status_pkg::SECURE_BIT]; // RL12
         current_lane_width <= block[sd_status_pkg::WIDTH_LSB +: sd_status_pkg::WIDTH_W]; // RL13
      end
   end

   // Interpretation of the captured codes
   assign tmoUnsupported = eraseTimeout == sd_status_pkg::TMO_NONE; // RL18
   assign moveInfinite   = movePerf == sd_status_pkg::MOVE_INF; // RL17
   assign moveUndefined  = movePerf == sd_status_pkg::MOVE_UNDEF; // RL17
   assign speedReserved  = speedCode > sd_status_pkg::SPEED_LAST; // RL15
   assign speedClassNum  = speedReserved ? 4'h0 : {speedCode[2:0], 1'b0}; // RL15
   assign auValid        = alloc_unit_length >= sd_status_pkg::AU_FIRST
                        && alloc_unit_length <= sd_status_pkg::AU_LAST; // RL16
   assign auKb           = auValid ? 13'(sd_status_pkg::AU_BASE_KB << (alloc_unit_length - sd_status_pkg::AU_FIRST))
                                   : 13'h0000; // RL16
   assign cardStandard   = card_variant_code[15:8] == sd_status_pkg::TYPE_STD_HI; // RL11
   assign cardReadWrite  = card_variant_code == sd_status_pkg::TYPE_RW; // RL11
   assign cardReadOnly   = card_variant_code == sd_status_pkg::TYPE_RO; // RL11
   assign widthFour      = current_lane_width == sd_status_pkg::WIDTH_FOUR; // RL13
   assign widthReserved  = current_lane_width != sd_status_pkg::WIDTH_FOUR
                        && current_lane_width != sd_status_pkg::WIDTH_ONE; // RL13

   always_comb begin
      readHit  = readHitFor(araddr);
      readWord = 32'h00000000;
      case (araddr)
         sd_status_pkg::OFS_CTRL:   readWord = 32'h00000000;
         sd_status_pkg::OFS_STATUS: readWord = {28'h0000000, captureArmed, refused, done,
                                                state != sd_status_pkg::ST_IDLE};
         sd_status_pkg::OFS_ERASE:  readWord = {eraseSize, 1'b0, tmoUnsupported, eraseTimeout,
                                                6'h00, eraseOffset};
         sd_status_pkg::OFS_PERF:   readWord = {speedCode, speedClassNum, 1'b0, speedReserved,
                                                moveUndefined, moveInfinite, movePerf,
                                                3'h0, auValid, alloc_unit_length};
         sd_status_pkg::OFS_PROT:   readWord = protected_region_length;
         sd_status_pkg::OFS_TYPE:   readWord = {8'h00, widthFour, widthReserved, current_lane_width,
                                                secure_operation_flag, cardReadOnly, cardReadWrite,
                                                cardStandard, card_variant_code};
         sd_status_pkg::OFS_AU:     readWord = {19'h00000, auKb};
         default:                   readWord = 32'h00000000;
      endcase
   end

   assign arready = !rvalid;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= sd_status_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= readWord;
         rresp  <= readHit ? sd_status_pkg::RESP_OKAY : sd_status_pkg::RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule : sd_status_decoder

/* shared/sd_status_pkg.sv */
// Constants for the card status block requester and decoder
// How it works
// [RL1] Card sends one 512-bit block; capture all first
// [RL2] Request is app prefix then status command
// [RL3] Request only while card selected, transfer state
// [RL4] Bit types: error, state, response, execution
// [RL5] Clear classes: current state, previous command, read
// [RL6] Bits 399:0 reserved; nothing extracted there
// [RL7] Allocation unit code at 431:428, 427:424 reserved
// [RL8] Move performance at 439:432, 1MB/s steps
// [RL9] Speed class code at 447:440
// [RL10] Protected region length, 32 bits at 479:448
// [RL11] Card variant at 495:480; 0000 rw, 0001 ro
// [RL12] Bit 509 secure flag; 508:496 reserved
// [RL13] Lane width at 511:510; 00 one, 10 four
// [RL14] Erase offset, timeout, size at 401:400, 407:402, 423:408
// [RL15] Speed codes 0..3 give class 0,2,4,6; rest reserved
// [RL16] Unit code 1..9 gives 16KB shifted; others invalid
// [RL17] Move FFh infinite, 00h undefined
// [RL18] Erase timeout 1..63 seconds; 0 unsupported
package sd_status_pkg;
   localparam int BLOCK_BITS = 512;
   localparam int CNT_W      = 10;
   localparam logic [CNT_W-1:0] LAST_BIT = 10'h1ff;

   localparam int ERASE_OFS_LSB  = 400;
   localparam int ERASE_OFS_W    = 2;
   localparam int ERASE_TMO_LSB  = 402;
   localparam int ERASE_TMO_W    = 6;
   localparam int ERASE_SIZE_LSB = 408;
   localparam int ERASE_SIZE_W   = 16;
   localparam int AU_LSB         = 428;
   localparam int AU_W           = 4;
   localparam int MOVE_LSB       = 432;
   localparam int MOVE_W         = 8;
   localparam int SPEED_LSB      = 440;
   localparam int SPEED_W        = 8;
   localparam int PROT_LSB       = 448;
   localparam int PROT_W         = 32;
   localparam int TYPE_LSB       = 480;
   localparam int TYPE_W         = 16;
   localparam int SECURE_BIT     = 509;
   localparam int WIDTH_LSB      = 510;
   localparam int WIDTH_W        = 2;

   localparam logic [5:0] CMD_APP_PREFIX = 6'h37;
   localparam logic [5:0] CMD_STATUS     = 6'h0d;

   localparam logic [7:0]  SPEED_LAST   = 8'h03;
   localparam logic [7:0]  MOVE_INF     = 8'hff;
   localparam logic [7:0]  MOVE_UNDEF   = 8'h00;
   localparam logic [3:0]  AU_FIRST     = 4'h1;
   localparam logic [3:0]  AU_LAST      = 4'h9;
   localparam logic [12:0] AU_BASE_KB   = 13'h0010;
   localparam logic [5:0]  TMO_NONE     = 6'h00;
   localparam logic [7:0]  TYPE_STD_HI  = 8'h00;
   localparam logic [15:0] TYPE_RW      = 16'h0000;
   localparam logic [15:0] TYPE_RO      = 16'h0001;
   localparam logic [1:0]  WIDTH_ONE    = 2'h0;
   localparam logic [1:0]  WIDTH_FOUR   = 2'h2;

   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ERASE  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_PERF   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_PROT   = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_TYPE   = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_AU     = 8'h18;

   localparam int CTRL_START    = 0;
   localparam int CTRL_CLR_DONE = 1;
   localparam int CTRL_CLR_REF  = 2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_APP  = 4'h2,
      ST_STAT = 4'h4,
      ST_WAIT = 4'h8
   } req_state_t;
endpackage : sd_status_pkg

/* verification/sd_card_model.sv */
// Card answering the status request
`timescale 1ns/1ns
module sd_card_model (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         cmdValid,
   input  wire logic [5:0]   cmdIndex,
   output logic              cmdReady,
   output logic              frameStart,
   output logic              bitIn,
   output logic              bitValid,
   input  wire logic [511:0] block,
   input  wire logic         slow,
   input  wire logic [9:0]   restartAfter
);
   logic appSeen;
   task automatic sendBits(input int n);
      int i;
      frameStart <= 1'b1;
      @(posedge mclk);
      frameStart <= 1'b0;
      for (i = 511; i > 511 - n; i--) begin
         if (slow) begin
            bitValid <= 1'b0;
            bitIn    <= ~bitIn;
            @(posedge mclk);
         end
         bitValid <= 1'b1;
         bitIn    <= block[i];
         @(posedge mclk);
      end
      bitValid <= 1'b0;
      bitIn    <= ~bitIn;
   endtask : sendBits
   initial begin
      cmdReady   = 1'b0;
      frameStart = 1'b0;
      bitIn      = 1'b0;
      bitValid   = 1'b0;
      appSeen    = 1'b0;
      forever begin
         @(posedge mclk);
         if (rst) begin
            appSeen = 1'b0;
            cmdReady <= 1'b0;
         end else if (cmdValid && cmdReady) begin
            cmdReady <= 1'b0;
            if (cmdIndex == sd_status_pkg::CMD_STATUS && appSeen) begin
               @(posedge mclk);
               if (restartAfter != 10'h000) sendBits(int'(restartAfter));
               sendBits(512);
            end
            appSeen = (cmdIndex == sd_status_pkg::CMD_APP_PREFIX);
         end else if (cmdValid) begin
            if (slow) repeat (3) @(posedge mclk);
            cmdReady <= 1'b1;
         end
      end
   end
endmodule : sd_card_model

/* verification/sd_status_props.sv */
// Port checker for the status block decoder
`timescale 1ns/1ns
module sd_status_props (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        awready,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        cardInTransfer,
   input wire logic        cmdValid,
   input wire logic [5:0]  cmdIndex,
   input wire logic        cmdReady,
   input wire logic        frameStart,
   input wire logic        bitValid,
   input wire logic        captureArmed
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   logic [9:0] bitCount;
   // Bits in the current frame
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bitCount <= 10'h000;
      end else if (frameStart || !captureArmed) begin
         bitCount <= 10'h000;
      end else if (bitValid) begin
         bitCount <= bitCount + 10'h001;
      end
   end
   sequence s_appTaken;
      cmdValid && cmdReady && cmdIndex == sd_status_pkg::CMD_APP_PREFIX;
   endsequence
   sequence s_statusTaken;
      cmdValid && cmdReady && cmdIndex == sd_status_pkg::CMD_STATUS;
   endsequence
   property p_appThenStatus;
      s_appTaken |=> cmdValid && cmdIndex == sd_status_pkg::CMD_STATUS;
   endproperty
   property p_armAfterStatus;
      s_statusTaken |=> captureArmed && !cmdValid;
   endproperty
   property p_fullBlock;
      $fell(captureArmed) |-> bitCount == 10'h200;
   endproperty
   property p_startNeedsCard;
      $rose(cmdValid) |-> $past(cardInTransfer);
   endproperty
   property p_cmdHold;
      cmdValid && !cmdReady |=> cmdValid && $stable(cmdIndex);
   endproperty
   property p_writeRefused;
      bvalid |-> !awready && !wready;
   endproperty
   property p_bRelease;
      bvalid && bready |=> !bvalid;
   endproperty
   property p_readRefused;
      rvalid |-> !arready;
   endproperty
   property p_readAnswer;
      arvalid && arready |=> rvalid;
   endproperty
   property p_readRelease;
      rvalid && rready |=> !rvalid;
   endproperty
   a_appThenStatus: assert property (p_appThenStatus) else $error("no status after prefix");
   a_armAfterStatus: assert property (p_armAfterStatus) else $error("not armed");
   a_fullBlock: assert property (p_fullBlock) else $error("short block");
   a_startNeedsCard: assert property (p_startNeedsCard) else $error("request outside transfer");
   a_cmdHold: assert property (p_cmdHold) else $error("command dropped");
   a_writeRefused: assert property (p_writeRefused) else $error("write taken while busy");
   a_bRelease: assert property (p_bRelease) else $error("bvalid stuck");
   a_readRefused: assert property (p_readRefused) else $error("read taken while busy");
   a_readAnswer: assert property (p_readAnswer) else $error("read data late");
   a_readRelease: assert property (p_readRelease) else $error("rvalid stuck");
endmodule : sd_status_props
bind sd_status_decoder sd_status_props u_sd_status_props (.*);

/* verification/tb.sv */
// Bench for the status block decoder
`timescale 1ns/1ns
module tb;
   localparam logic [39:0] SPEEDS = 40'h04_03_02_01_00;
   localparam logic [39:0] MOVES  = 40'hfe_7f_01_ff_00;
   localparam logic [19:0] UNITS  = 20'h5_a_9_1_0;
   localparam logic [9:0]  WIDTHS = 10'b11_01_10_00_10;
   logic         mclk = 1'b0, rst = 1'b1, cardInTransfer = 1'b1, slow = 1'b0;
   logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]  wdata = 32'h0, rdata;
   logic [3:0]   wstrb = 4'h0;
   logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic         awready, wready, bvalid, arready, rvalid, cmdValid, cmdReady, frameStart, bitIn, bitValid;
   logic         captureArmed;
   logic [1:0]   bresp, rresp;
   logic [5:0]   cmdIndex;
   logic [511:0] blk = '0;
   logic [9:0]   restartAfter = 10'h000;
   int           mismatches = 0, checked = 0;
   sd_status_decoder u_sd_status_decoder (
      .mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .cardInTransfer(cardInTransfer), .cmdValid(cmdValid), .cmdIndex(cmdIndex),
      .cmdReady(cmdReady), .frameStart(frameStart), .bitIn(bitIn), .bitValid(bitValid),
      .captureArmed(captureArmed)
   );
   sd_card_model u_sd_card_model (
      .mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmdIndex(cmdIndex), .cmdReady(cmdReady),
      .frameStart(frameStart), .bitIn(bitIn), .bitValid(bitValid), .block(blk), .slow(slow),
      .restartAfter(restartAfter)
   );
   initial begin
      forever #5 mclk = ~mclk;
   end
   task automatic conclude();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   task automatic hang();
      mismatches++;
      $display("ERROR %0t: timeout", $time);
      conclude();
   endtask : hang
   task automatic compare(input logic [31:0] got, input logic [31:0] exp, input logic [7:0] a);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: %h got %h exp %h", $time, a, got, exp);
      end
   endtask : compare
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge mclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 100) hang();
      compare({30'h0, bresp}, {30'h0, er}, a);
   endtask : axiWrite
   task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge mclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n == 100) hang();
   endtask : axiRead
   task automatic expectReg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axiRead(a, d, r);
      compare(d, e, a);
      compare({30'h0, r}, {30'h0, er}, a);
   endtask : expectReg
   // Expected register image
   function automatic logic [31:0] expReg(input logic [7:0] a, input logic [511:0] b);
      logic [7:0]  sp, mv;
      logic [3:0]  au;
      logic [5:0]  tm;
      logic [1:0]  w;
      logic [15:0] ty;
      sp = b[447:440];
      mv = b[439:432];
      au = b[431:428];
      tm = b[407:402];
      w  = b[511:510];
      ty = b[495:480];
      case (a)
         8'h08: expReg = {b[423:408], 1'b0, tm == 6'h00, tm, 6'h00, b[401:400]};
         8'h0c: expReg = {sp, ((sp <= 8'h03) ? sp[3:0] << 1 : 4'h0), 1'b0, sp > 8'h03, mv == 8'h00,
                          mv == 8'hff, mv, 3'h0, au >= 4'h1 && au <= 4'h9, au};
         8'h10: expReg = b[479:448];
         8'h14: expReg = {8'h00, w == 2'h2, w[0], w, b[509], ty == 16'h0001, ty == 16'h0000, ty[15:8] == 8'h00, ty};
         default: expReg = (au >= 4'h1 && au <= 4'h9) ? 32'h10 << (au - 4'h1) : 32'h0;
      endcase
   endfunction : expReg
   initial begin
      logic [31:0] stat;
      logic [1:0]  r;
      int          k, n, a;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      expectReg(8'h04, 32'h0, 2'h0);
      expectReg(8'h00, 32'h0, 2'h0);
      expectReg(8'h1c, 32'h0, 2'h2);
      axiWrite(8'h1c, 32'h1, 2'h2);
      expectReg(8'h04, 32'h0, 2'h0);
      $display("test map done");
      cardInTransfer <= 1'b0;
      axiWrite(8'h00, 32'h1, 2'h0);
      expectReg(8'h04, 32'h4, 2'h0);
      cardInTransfer <= 1'b1;
      axiWrite(8'h00, 32'h4, 2'h0);
      expectReg(8'h04, 32'h0, 2'h0);
      $display("test refusal done");
      for (k = 0; k < 5; k++) begin
         slow <= k[0];
         restartAfter <= (k == 3) ? 10'd100 : 10'd0;
         blk <= {WIDTHS[k*2+:2], k[0], 13'h1abc, ((k == 2) ? 16'h0100 : {15'h0, k[0]}), 32'h1234_5678 ^ k,
                 SPEEDS[k*8+:8], MOVES[k*8+:8], UNITS[k*4+:4], 4'h5, 16'h00a5 + k[15:0],
                 ((k == 0) ? 6'h00 : 6'h3f), k[1:0], {12{32'h5a3c96e1}}, 16'hc3a5};
         axiWrite(8'h00, 32'h1, 2'h0);
         if (k == 0) axiWrite(8'h00, 32'h1, 2'h0);
         n = 0;
         stat = 32'h0;
         while (!stat[1] && n < 1000) begin
            axiRead(8'h04, stat, r);
            n++;
         end
         if (n == 1000) hang();
         compare(stat, (k == 0) ? 32'h6 : 32'h2, 8'h04);
         for (a = 8; a <= 24; a += 4) expectReg(a[7:0], expReg(a[7:0], blk), 2'h0);
         axiWrite(8'h00, 32'h6, 2'h0);
         $display("test block %0d done", k);
      end
      expectReg(8'h04, 32'h0, 2'h0);
      conclude();
   end
endmodule : tb
